// *** logic/legacy_mode_protection.sv ***
// Legacy-mode protection unit: address formation, privilege and I/O
// checks, and legacy-mode flag control, reached over APB.
// Assumes synchronous APB inputs on CORE_CLK_IN and software that fills
// the task state image before issuing port checks.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ns

// Notes on behaviour
// - In legacy mode, linear address is segment shifted left four plus offset.
// - In legacy mode, an offset above FFFFH raises fault 13.
// - Every task switch reloads the page directory base from the incoming image.
// - Legacy-mode code always runs at privilege level 3 with full checks.
// - Privileged instructions fault 13 in protected mode whenever privilege level is above 0.
// - Protected-only instructions fault 6 in real or legacy mode.
// - Legacy mode applies the I/O level check to interrupt and flag instructions.
// - Breakpoint, overflow trap and bounds check skip the I/O level check.
// - Legacy-mode port accesses use the permission bitmap, not the level check.
// - Bitmap pointer is the 16-bit word at offset 66H of task state.
// - Each port byte has one bit; any covering bit set raises fault 13.
// - Bitmap bits beyond the task state limit deny the port.
// - Interrupt from legacy mode goes to level 0, clears flag, saves it set.
// - Flag set only by 32-bit return at level 0 or task switch.
// - Pop flags, and returns in real or legacy mode, never change the flag.
// - Push flags always stores the legacy-mode bit as zero.
// - Legacy-mode interrupts vector through the protected descriptor table.
// - Gate to conforming or nonzero-level code faults with selector as code.
// - Switching out of legacy mode saves flags with the legacy bit set.
// - Incoming flags load before segments, so segments load as shifted bases.
module legacy_mode_protection
	import legacy_mode_pkg::*;
#(
	parameter int TSS_WORDS = 64
) (
	input  wire logic        CORE_CLK_IN,
	input  wire logic        RST_N_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	output logic             LEGACY_MODE_OUT,
	output logic      [1:0]  CPL_OUT,
	output logic             FAULT_OUT
);

	localparam int AW = $clog2(TSS_WORDS);

	typedef struct packed {
		logic        legacy;
		logic [1:0]  current_privilege_level;
		logic        prot;
		logic [1:0]  io_privilege_level;
		logic [15:0] seg;
		logic [31:0] offs;
		logic [15:0] port;
		logic [2:0]  psize;
		logic [15:0] limit;
		logic [31:0] image;
		logic [31:0] pdb_img;
		logic [31:0] pdb;
		logic        fault;
		logic [7:0]  vec;
		logic [15:0] err;
		logic [31:0] linear;
		logic [31:0] pushed;
		logic [AW-1:0] taddr;
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
	} state_t;

	state_t      q;
	state_t      d;
	logic [31:0] tss_mem [TSS_WORDS];

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic        acc;
	logic        wr;
	logic        cmd_fire;
	op_t         cmd_op;
	logic [31:0] vm_mask;

	// A transfer completes only on the edge where our registered ready is high
	assign acc      = PSEL_IN & PENABLE_IN & q.ready;
	assign wr       = acc & PWRITE_IN;
	assign cmd_fire = wr & (PADDR_IN == A_CMD);
	assign cmd_op   = op_t'(PWDATA_IN[CMD_OP_LO +: 4]);
	assign vm_mask  = 32'h0000_0001 << LEGACY_BIT;

	////////////////////////////////////////////////////////////////////////
	// Privilege helpers
	logic [1:0] cpl_eff;
	logic       above_io_privilege_level;

	// Forced to user level while the legacy flag is up
	assign cpl_eff    = q.legacy ? CPL_USER : q.current_privilege_level;
	assign above_io_privilege_level = cpl_eff > q.io_privilege_level;

	////////////////////////////////////////////////////////////////////////
	// Permission bitmap lookup in the task state image
	function automatic logic [7:0] tss_byte(input logic [15:0] a);
		logic [7:0] b;
		b = 8'hFF;
		// Bytes past the stored image read as all ones, which denies
		if (a[15:2] < TSS_WORDS) begin
			b = tss_mem[a[AW+1:2]][{a[1:0], 3'h0} +: 8];
		end
		return b;
	endfunction

	logic [15:0] map_ptr;
	logic [15:0] map_byte;
	logic [16:0] map_next;
	logic [15:0] map_win;
	logic [3:0]  size_mask;
	logic        io_deny;

	// Pointer, then the two bytes that can hold a port's bits
	assign map_ptr   = {tss_byte(MAP_PTR_OFFS + 16'h0001), tss_byte(MAP_PTR_OFFS)};
	assign map_byte  = map_ptr + {3'h0, q.port[15:3]};
	assign map_next  = {1'b0, map_byte} + 17'h0_0001;
	assign map_win   = {tss_byte(map_next[15:0]), tss_byte(map_byte)} >> q.port[2:0];
	assign size_mask = (q.psize == SIZE_DWORD) ? 4'hF : (q.psize == SIZE_WORD) ? 4'h3 : 4'h1;
	// Also deny when the pair runs past the limit; the terminator makes this safe
	assign io_deny   = (|(map_win[3:0] & size_mask))
	                 | (map_next > {1'b0, q.limit});

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic gp;
		logic gate_bad;
		logic new_vm;
		gp       = 1'b0;
		gate_bad = PWDATA_IN[CMD_CONF] | (PWDATA_IN[CMD_DPL_LO +: 2] != CPL_KERNEL);
		new_vm   = q.prot & q.image[LEGACY_BIT];
		d        = q;
		d.ready  = PSEL_IN & PENABLE_IN & ~q.ready;
		d.slverr = 1'b0;

		// Read data and error are registered on the same edge that raises ready
		if (d.ready) begin
			d.rdata = 32'h0000_0000;
			case (PADDR_IN)
				A_MODE: begin
					d.rdata[MODE_PROT]            = q.prot;
					d.rdata[MODE_LEGACY]          = q.legacy;
					d.rdata[MODE_CPL_LO +: 2]     = cpl_eff;
					d.rdata[MODE_IO_PRIVILEGE_LEVEL_LO +: 2]    = q.io_privilege_level;
				end
				A_SEG:     d.rdata[15:0] = q.seg;
				A_OFFS:    d.rdata = q.offs;
				A_PORT:    d.rdata = {13'h0000, q.psize, q.port};
				A_LIMIT:   d.rdata[15:0] = q.limit;
				A_IMAGE:   d.rdata = q.image;
				A_PDB_IMG: d.rdata = q.pdb_img;
				A_CMD:     d.rdata = 32'h0000_0000;
				A_STATUS: begin
					d.rdata[ST_VEC_LO +: 8]  = q.vec;
					d.rdata[ST_FAULT]        = q.fault;
					d.rdata[ST_ERR_LO +: 16] = q.err;
				end
				A_LINEAR:  d.rdata = q.linear;
				A_PDB:     d.rdata = q.pdb;
				A_PUSHED:  d.rdata = q.pushed;
				A_TADDR:   d.rdata[AW-1:0] = q.taddr;
				A_TDATA:   d.rdata = tss_mem[q.taddr];
				default:   d.slverr = 1'b1;
			endcase
		end

		// Register writes; the command register is handled below
		if (wr) begin
			case (PADDR_IN)
				A_MODE: begin
					d.prot = PWDATA_IN[MODE_PROT];
					d.io_privilege_level = PWDATA_IN[MODE_IO_PRIVILEGE_LEVEL_LO +: 2];
					// Level cannot be lowered by software while in legacy mode
					if (!q.legacy) begin
						d.current_privilege_level = PWDATA_IN[MODE_CPL_LO +: 2];
					end
				end
				A_SEG:     d.seg = PWDATA_IN[15:0];
				A_OFFS:    d.offs = PWDATA_IN;
				A_PORT: begin
					d.port  = PWDATA_IN[15:0];
					d.psize = PWDATA_IN[PORT_SIZE_LO +: 3];
				end
				A_LIMIT:   d.limit = PWDATA_IN[15:0];
				A_IMAGE:   d.image = PWDATA_IN;
				A_PDB_IMG: d.pdb_img = PWDATA_IN;
				A_TADDR:   d.taddr = PWDATA_IN[AW-1:0];
				default:   ;
			endcase
		end

		// Each command replaces the previous outcome
		if (cmd_fire) begin
			d.fault = 1'b0;
			d.vec   = VEC_NONE;
			d.err   = 16'h0000;
			case (cmd_op)
				OP_MEM: begin
					d.linear = q.legacy ? (({16'h0000, q.seg} << SEG_SHIFT) + q.offs) : q.offs;
					gp       = q.legacy & (q.offs > OFFSET_LIMIT);
				end
				// Real mode runs at level 0, so this only bites when protected
				OP_PRIV:      gp = q.prot & (cpl_eff != CPL_KERNEL);
				OP_PROT_ONLY: begin
					if (!q.prot || q.legacy) begin
						d.fault = 1'b1;
						d.vec   = VEC_UD;
					end
				end
				// Interrupt-flag changes are level-gated in both protected forms
				OP_STI, OP_CLI: gp = q.prot & above_io_privilege_level;
				OP_INTN:        gp = q.legacy & above_io_privilege_level;
				OP_POP_FLAGS_INSTR:        gp = q.legacy & above_io_privilege_level;
				OP_PUSH_FLAGS_INSTR: begin
					gp = q.legacy & above_io_privilege_level;
					if (!gp) begin
						d.pushed = q.image & ~vm_mask;
					end
				end
				OP_INTERRUPT_RETURN_INSTR: begin
					gp = q.legacy & above_io_privilege_level;
					// Only a wide return from protected level 0 may raise the flag
					if (q.prot && !q.legacy && q.current_privilege_level == CPL_KERNEL &&
					    PWDATA_IN[CMD_WIDE] && q.image[LEGACY_BIT]) begin
						d.legacy = 1'b1;
						d.current_privilege_level    = CPL_USER;
					end
				end
				OP_EXEMPT: ;
				OP_IO:  gp = q.legacy ? io_deny : (q.prot & above_io_privilege_level & io_deny);
				OP_INTR: begin
					if (q.legacy && gate_bad) begin
						gp = 1'b1;
						d.err = PWDATA_IN[CMD_SEL_LO +: 16];
					end else begin
						d.vec    = PWDATA_IN[CMD_VEC_LO +: 8];
						d.pushed = (q.image & ~vm_mask) | (q.legacy ? vm_mask : 32'h0000_0000);
						d.legacy = 1'b0;
						d.current_privilege_level    = CPL_KERNEL;
					end
				end
				OP_TSWITCH: begin
					// Outgoing flags image keeps the bit of the task being left
					d.pushed = q.legacy ? vm_mask : 32'h0000_0000;
					d.pdb    = q.pdb_img;
					d.legacy = new_vm;
					d.current_privilege_level    = new_vm ? CPL_USER : PWDATA_IN[CMD_SEL_LO +: 2];
					// Flags first: segment loads as a shifted base under the new flag
					d.linear = new_vm ? ({16'h0000, q.seg} << SEG_SHIFT) : {16'h0000, q.seg};
				end
				default: ;
			endcase
			if (gp) begin
				d.fault = 1'b1;
				d.vec   = VEC_GP;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Task state image; no reset, software fills it before use
	always_ff @(posedge CORE_CLK_IN) begin
		if (wr && PADDR_IN == A_TDATA) begin
			tss_mem[q.taddr] <= PWDATA_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign PRDATA_OUT      = q.rdata;
	assign PREADY_OUT      = q.ready;
	assign PSLVERR_OUT     = q.slverr;
	assign LEGACY_MODE_OUT = q.legacy;
	assign CPL_OUT         = q.current_privilege_level;
	assign FAULT_OUT       = q.fault;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	logic gate_bad_w;
	logic entry_cmd;
	// Gate target check as seen on the command word
	assign gate_bad_w = PWDATA_IN[CMD_CONF] | (PWDATA_IN[CMD_DPL_LO +: 2] != CPL_KERNEL);
	assign entry_cmd  = cmd_fire & ((cmd_op == OP_INTERRUPT_RETURN_INSTR) | (cmd_op == OP_TSWITCH));

	sequence s_cmd(op_t o);
		cmd_fire && cmd_op == o;
	endsequence

	sequence s_gp_next;
		##1 q.fault && q.vec == VEC_GP;
	endsequence

	a_shift_address: assert property (s_cmd(OP_MEM) ##0 q.legacy |=>
		q.linear == ({12'h000, $past(q.seg), 4'h0} + $past(q.offs)))
		else $error("legacy linear address wrong");
	a_offset_limit: assert property (s_cmd(OP_MEM) ##0 (q.legacy && q.offs > OFFSET_LIMIT) |-> s_gp_next)
		else $error("offset above limit not faulted");
	a_pdb_reload: assert property (s_cmd(OP_TSWITCH) |=> q.pdb == $past(q.pdb_img))
		else $error("page base not reloaded");
	a_legacy_level: assert property (q.legacy |-> q.current_privilege_level == CPL_USER)
		else $error("legacy mode below user level");
	a_priv_fault: assert property (s_cmd(OP_PRIV) ##0 (q.prot && cpl_eff != CPL_KERNEL) |-> s_gp_next)
		else $error("privileged op not faulted");
	a_prot_only: assert property (s_cmd(OP_PROT_ONLY) ##0 (!q.prot || q.legacy) |=>
		q.fault && q.vec == VEC_UD)
		else $error("protected-only op not faulted");
	a_io_privilege_level_gate: assert property (s_cmd(OP_INTN) ##0 (q.legacy && above_io_privilege_level) |-> s_gp_next)
		else $error("level-gated op not faulted");
	a_exempt_pass: assert property (s_cmd(OP_EXEMPT) |=> !q.fault)
		else $error("exempt op faulted");
	a_io_bitmap: assert property (s_cmd(OP_IO) ##0 q.legacy |=> q.fault == $past(io_deny))
		else $error("legacy port check wrong");
	a_intr_exit: assert property (s_cmd(OP_INTR) ##0 (q.legacy && !gate_bad_w) |=>
		!q.legacy && q.current_privilege_level == CPL_KERNEL && q.pushed[LEGACY_BIT])
		else $error("interrupt exit from legacy wrong");
	a_entry_only: assert property ($rose(q.legacy) |-> $past(entry_cmd))
		else $error("legacy flag set without entry");
	a_pop_flags_instr_keep: assert property (s_cmd(OP_POP_FLAGS_INSTR) |=> $stable(q.legacy))
		else $error("pop flags changed legacy flag");
	a_push_flags_instr_zero: assert property (s_cmd(OP_PUSH_FLAGS_INSTR) |=> !q.pushed[LEGACY_BIT])
		else $error("push flags stored legacy bit");
	a_gate_fault: assert property (s_cmd(OP_INTR) ##0 (q.legacy && gate_bad_w) |=>
		q.fault && q.err == $past(PWDATA_IN[CMD_SEL_LO +: 16]) ##1 !$rose(q.legacy))
		else $error("bad gate not faulted");

endmodule

// *** logic/legacy_mode_pkg.sv ***
// Constants for the legacy-mode protection unit: register map, field
// positions, exception vectors and command codes.
// Assumes one APB slave with 8-bit byte addresses and 32-bit data.
package legacy_mode_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [7:0] A_MODE    = 8'h00;
	localparam logic [7:0] A_SEG     = 8'h04;
	localparam logic [7:0] A_OFFS    = 8'h08;
	localparam logic [7:0] A_PORT    = 8'h0C;
	localparam logic [7:0] A_LIMIT   = 8'h10;
	localparam logic [7:0] A_IMAGE   = 8'h14;
	localparam logic [7:0] A_PDB_IMG = 8'h18;
	localparam logic [7:0] A_CMD     = 8'h1C;
	localparam logic [7:0] A_STATUS  = 8'h20;
	localparam logic [7:0] A_LINEAR  = 8'h24;
	localparam logic [7:0] A_PDB     = 8'h28;
	localparam logic [7:0] A_PUSHED  = 8'h2C;
	localparam logic [7:0] A_TADDR   = 8'h30;
	localparam logic [7:0] A_TDATA   = 8'h34;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int MODE_PROT    = 0;
	localparam int MODE_LEGACY  = 1;
	localparam int MODE_CPL_LO  = 2;
	localparam int MODE_IO_PRIVILEGE_LEVEL_LO = 4;
	localparam int CMD_OP_LO    = 0;
	localparam int CMD_CONF     = 4;
	localparam int CMD_DPL_LO   = 5;
	localparam int CMD_WIDE     = 7;
	localparam int CMD_VEC_LO   = 8;
	localparam int CMD_SEL_LO   = 16;
	localparam int ST_VEC_LO    = 0;
	localparam int ST_FAULT     = 8;
	localparam int ST_ERR_LO    = 16;
	localparam int PORT_SIZE_LO = 16;
	localparam int LEGACY_BIT   = 17;

	////////////////////////////////////////////////////////////////////////
	// Values
	localparam logic [7:0]  VEC_NONE     = 8'h00;
	localparam logic [7:0]  VEC_GP       = 8'h0D;
	localparam logic [7:0]  VEC_UD       = 8'h06;
	localparam logic [31:0] OFFSET_LIMIT = 32'h0000_FFFF;
	localparam int          SEG_SHIFT    = 4;
	localparam logic [15:0] MAP_PTR_OFFS = 16'h0066;
	localparam logic [1:0]  CPL_USER     = 2'h3;
	localparam logic [1:0]  CPL_KERNEL   = 2'h0;
	localparam logic [2:0]  SIZE_WORD    = 3'h2;
	localparam logic [2:0]  SIZE_DWORD   = 3'h4;

	// Command codes written to the low nibble of the command register
	typedef enum logic [3:0] {
		OP_NONE      = 4'h0,
		OP_MEM       = 4'h1,
		OP_PRIV      = 4'h2,
		OP_PROT_ONLY = 4'h3,
		OP_INTN      = 4'h4,
		OP_STI       = 4'h5,
		OP_CLI       = 4'h6,
		OP_PUSH_FLAGS_INSTR     = 4'h7,
		OP_POP_FLAGS_INSTR      = 4'h8,
		OP_INTERRUPT_RETURN_INSTR      = 4'h9,
		OP_EXEMPT    = 4'hA,
		OP_IO        = 4'hB,
		OP_INTR      = 4'hC,
		OP_TSWITCH   = 4'hD
	} op_t;

endpackage

// *** verif/legacy_mode_protection_tb.sv ***
// Self-checking bench for the legacy-mode protection unit, driven over APB.
// Assumes no wait count; the watchdog ends a transfer that never completes.
`timescale 1ns/1ns
module legacy_mode_protection_tb;
	import legacy_mode_pkg::*;
	typedef struct packed {
		logic [31:0] mode;
		logic [31:0] cmd;
		logic [8:0]  exp;
	} row_t;
	typedef struct packed {
		logic [31:0] ptr;
		logic [31:0] lim;
		logic [31:0] port;
		logic [8:0]  exp;
	} io_t;
	logic        core_clk    = 1'b0;
	logic        rst_n       = 1'b0;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [7:0]  paddr       = 8'h00;
	logic [31:0] pwdata      = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        legacy;
	logic [1:0]  current_privilege_level;
	logic        fault;
	logic [31:0] r;
	logic        e;
	int          failures    = 0;
	int          comparisons = 0;
	row_t        rows [18];
	io_t         ios [7];

	////////////////////////////////////////////////////////////////////////
	// Clock and unit under test
	always #10 core_clk = ~core_clk;

	legacy_mode_protection #(
		.TSS_WORDS (64)
	) uut (
		.CORE_CLK_IN     (core_clk),
		.RST_N_IN        (rst_n),
		.PSEL_IN         (psel),
		.PENABLE_IN      (penable),
		.PWRITE_IN       (pwrite),
		.PADDR_IN        (paddr),
		.PWDATA_IN       (pwdata),
		.PRDATA_OUT      (prdata),
		.PREADY_OUT      (pready),
		.PSLVERR_OUT     (pslverr),
		.LEGACY_MODE_OUT (legacy),
		.CPL_OUT         (current_privilege_level),
		.FAULT_OUT       (fault)
	);

	////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and bus tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Request is held until ready is sampled high, so no wait count is assumed
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Only the watchdog may end a wait for ready
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		check({31'h0, pready}, 32'h0000_0001);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		apb(1'b0, a, 32'h0000_0000);
		check(r & m, exp);
	endtask

	// Mode outputs are looked at mid-cycle, after the commit edge has landed
	task automatic outs(input logic l, input logic [1:0] c);
		@(negedge core_clk);
		check({29'h0, legacy, current_privilege_level}, {29'h0, l, c});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog: the whole run needs well under 20k cycles
	initial begin
		#1_000_000;
		failures++;
		report_and_stop;
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rows = '{
			'{32'h0000_0001, 32'h0000_0002, 9'h10D}, '{32'h0000_0001, 32'h0000_0003, 9'h106},
			'{32'h0000_0001, 32'h0000_0004, 9'h10D}, '{32'h0000_0001, 32'h0000_0005, 9'h10D},
			'{32'h0000_0001, 32'h0000_0006, 9'h10D}, '{32'h0000_0001, 32'h0000_0007, 9'h10D},
			'{32'h0000_0001, 32'h0000_0008, 9'h10D}, '{32'h0000_0001, 32'h0000_0089, 9'h10D},
			'{32'h0000_0001, 32'h0000_000A, 9'h000}, '{32'h0000_0031, 32'h0000_0004, 9'h000},
			'{32'h0000_0031, 32'h0000_0005, 9'h000}, '{32'h0000_0031, 32'h0000_0006, 9'h000},
			'{32'h0000_0031, 32'h0000_0007, 9'h000}, '{32'h0000_0031, 32'h0000_0008, 9'h000},
			'{32'h0000_0031, 32'h0000_0089, 9'h000}, '{32'h0000_0031, 32'h0000_0002, 9'h10D},
			'{32'h0000_0031, 32'h0000_0003, 9'h106}, '{32'h0000_0031, 32'h0000_000A, 9'h000}};
		// Bitmap at 80H: port 0 denied, 1..7 open, terminator at 81H
		ios = '{
			'{32'h0080_0000, 32'h0000_0081, 32'h0001_0001, 9'h000},
			'{32'h0080_0000, 32'h0000_0081, 32'h0001_0000, 9'h10D},
			'{32'h0080_0000, 32'h0000_0081, 32'h0004_0002, 9'h000},
			'{32'h0080_0000, 32'h0000_0081, 32'h0004_0006, 9'h10D},
			'{32'h0080_0000, 32'h0000_0081, 32'h0002_0007, 9'h10D},
			'{32'h0080_0000, 32'h0000_0080, 32'h0001_0001, 9'h10D},
			'{32'h00F0_0000, 32'h0000_0081, 32'h0001_0001, 9'h10D}};
		repeat (16) @(posedge core_clk);
		check({26'h0, pready, pslverr, legacy, current_privilege_level, fault}, 32'h0000_0000);
		rst_n <= 1'b1;
		rdchk(A_MODE, 32'h0000_0000, 32'hFFFF_FFFF);
		// Returns and flag pops that must not enter legacy mode, then the wide level-0 return that does
		wr(A_IMAGE, 32'h0002_0000);
		wr(A_CMD, 32'h0000_0089);
		outs(1'b0, 2'h0);
		wr(A_MODE, 32'h0000_0001);
		wr(A_CMD, 32'h0000_0008);
		outs(1'b0, 2'h0);
		wr(A_CMD, 32'h0000_0009);
		outs(1'b0, 2'h0);
		wr(A_MODE, 32'h0000_000D);
		wr(A_CMD, 32'h0000_0089);
		outs(1'b0, 2'h3);
		wr(A_MODE, 32'h0000_0001);
		wr(A_CMD, 32'h0000_0089);
		outs(1'b1, 2'h3);
		rdchk(A_MODE, 32'h0000_000F, 32'h0000_003F);
		// Instruction classes in legacy mode; level writes must be ignored
		wr(A_IMAGE, 32'h0000_0000);
		foreach (rows[i]) begin
			wr(A_MODE, rows[i].mode);
			wr(A_CMD, rows[i].cmd);
			outs(1'b1, 2'h3);
			check({31'h0, fault}, {31'h0, rows[i].exp[8]});
			rdchk(A_STATUS, {23'h0, rows[i].exp}, 32'h0000_01FF);
		end
		// Address formation at the offset boundary
		wr(A_SEG, 32'h0000_1234);
		wr(A_OFFS, 32'h0000_FFFF);
		wr(A_CMD, 32'h0000_0001);
		rdchk(A_LINEAR, 32'h0002_233F, 32'hFFFF_FFFF);
		rdchk(A_STATUS, 32'h0000_0000, 32'h0000_01FF);
		wr(A_OFFS, 32'h0001_0000);
		wr(A_CMD, 32'h0000_0001);
		rdchk(A_STATUS, 32'h0000_010D, 32'h0000_01FF);
		wr(A_MODE, 32'h0000_0031);
		wr(A_IMAGE, 32'hFFFF_FFFF);
		wr(A_CMD, 32'h0000_0007);
		rdchk(A_PUSHED, 32'hFFFD_FFFF, 32'hFFFF_FFFF);
		// Port checks with the I/O level at 3: only the bitmap may decide
		wr(A_TADDR, 32'h0000_0020);
		wr(A_TDATA, 32'hFFFF_FF01);
		wr(A_TADDR, 32'h0000_0019);
		foreach (ios[i]) begin
			wr(A_TDATA, ios[i].ptr);
			wr(A_LIMIT, ios[i].lim);
			wr(A_PORT, ios[i].port);
			wr(A_CMD, 32'h0000_000B);
			rdchk(A_STATUS, {23'h0, ios[i].exp}, 32'h0000_01FF);
		end
		// Gates: bad target faults with the selector, good one leaves legacy
		wr(A_MODE, 32'h0000_0001);
		wr(A_IMAGE, 32'h0000_0000);
		wr(A_CMD, 32'h0050_211C);
		rdchk(A_STATUS, 32'h0050_010D, 32'hFFFF_01FF);
		wr(A_CMD, 32'h0050_212C);
		rdchk(A_STATUS, 32'h0050_010D, 32'hFFFF_01FF);
		outs(1'b1, 2'h3);
		wr(A_CMD, 32'h0050_210C);
		outs(1'b0, 2'h0);
		rdchk(A_STATUS, 32'h0000_0021, 32'h0000_01FF);
		rdchk(A_PUSHED, 32'h0002_0000, 32'hFFFF_FFFF);
		// Task switch in and back out of legacy mode
		wr(A_IMAGE, 32'h0002_0000);
		wr(A_PDB_IMG, 32'hABCD_E000);
		wr(A_CMD, 32'h0000_000D);
		outs(1'b1, 2'h3);
		rdchk(A_PDB, 32'hABCD_E000, 32'hFFFF_FFFF);
		rdchk(A_LINEAR, 32'h0001_2340, 32'hFFFF_FFFF);
		rdchk(A_PUSHED, 32'h0000_0000, 32'h0002_0000);
		wr(A_IMAGE, 32'h0000_0000);
		wr(A_PDB_IMG, 32'h1111_1000);
		wr(A_CMD, 32'h0000_000D);
		outs(1'b0, 2'h0);
		rdchk(A_PUSHED, 32'h0002_0000, 32'h0002_0000);
		rdchk(A_PDB, 32'h1111_1000, 32'hFFFF_FFFF);
		rdchk(A_LINEAR, 32'h0000_1234, 32'hFFFF_FFFF);
		// Reset in mid-run while in legacy mode must clear flag and level
		wr(A_IMAGE, 32'h0002_0000);
		wr(A_CMD, 32'h0000_000D);
		outs(1'b1, 2'h3);
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		check({26'h0, pready, pslverr, legacy, current_privilege_level, fault}, 32'h0000_0000);
		rst_n <= 1'b1;
		rdchk(A_MODE, 32'h0000_0000, 32'hFFFF_FFFF);
		// Unmapped address and write-only command register
		apb(1'b0, 8'h40, 32'h0000_0000);
		check({31'h0, e}, 32'h0000_0001);
		check(r, 32'h0000_0000);
		rdchk(A_CMD, 32'h0000_0000, 32'hFFFF_FFFF);
		report_and_stop;
	end
endmodule
